//--- design/cpx_coproc.sv
// external coprocessor: pipeline follower, handshake and register bank
// Notes on behaviour
// RULE1: reset marks both follower slots invalid
// RULE2: state changes only when bus cycle enabled; here the load fifo also drains into the bank on stalled clocks
// RULE3: capture fetch word after previous opcode cycle
// RULE4: advance on current opcode fetch cycle
// RULE5: refill prefetches flush stale follower slots
// RULE6: never capture words in compressed state
// RULE7: accept only matching coprocessor number
// RULE8: core commits when executing, passed, accepted
// RULE9: decline with absent and busy high
// RULE10: accept immediately with both low
// RULE11: busy-wait is absent low, busy high
// RULE12: commit high abandons, keep tracking pipeline
// RULE13: no state change before actual commit
// RULE14: data op touches own registers only
// RULE15: at most sixteen words per transfer
// RULE16: separate 32-bit in, write, out paths
// RULE17: system ANDs absent/busy, muxes data
// RULE18: without coprocessor tie absent/busy high
// RULE19: core traps unaccepted coprocessor instructions
// RULE20: privilege sampled with the instruction
// RULE21: user access to guarded function declined
// RULE22: bus cycle ends on enabled edge
// RULE23: ids fourteen and fifteen are reserved
// RULE24: drive data only for committed returns
`timescale 1ns/100ps
`default_nettype none
`include "cpx_defines.svh"
module cpx_coproc #(
    parameter logic [3:0] CP_ID = `CPX_ID_DEFAULT,
    parameter logic [15:0] PRIV_MASK = `CPX_PRIV_MASK_DEFAULT
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic bus_cycle_enable,
    // pipeline following from the core
    input wire logic follow_mem_request_n,
    input wire logic follow_sequential,
    input wire logic follow_privilege,
    input wire logic follow_opcode_fetch_n,
    input wire logic follow_compressed_state,
    // handshake
    input wire logic coproc_commit_n,
    output logic coproc_absent,
    output logic coproc_busy,
    // data paths
    input wire logic [31:0] read_data,
    input wire logic [31:0] write_data,
    output logic [31:0] coproc_data_out,
    output logic coproc_data_drive
);
    import cpx_pkg::*;

    // follower state
    logic prev_fetch_r, prev_fetch_nxt;
    logic prev_data_r, prev_data_nxt;
    logic [31:0] fet_word_r, fet_word_nxt;
    logic fet_priv_r, fet_priv_nxt;
    logic fet_vld_r, fet_vld_nxt;
    logic [31:0] dec_word_r, dec_word_nxt;
    cpx_class_type dec_cls_r, dec_cls_nxt;
    logic dec_own_r, dec_own_nxt;
    logic dec_done_r, dec_done_nxt;
    // execution state
    cpx_xfer_type xs_r, xs_nxt;
    logic [4:0] xfer_cnt_r, xfer_cnt_nxt;
    logic [3:0] ptr_r, ptr_nxt;
    logic mcr_pend_r, mcr_pend_nxt;
    logic [3:0] mcr_reg_r, mcr_reg_nxt;
    logic absent_r, absent_nxt;
    logic busy_r, busy_nxt;
    logic [31:0] dout_r, dout_nxt;
    logic drive_r, drive_nxt;
    logic [31:0] bank_r [`CPX_REG_COUNT];
    // decode and fifo wires
    cpx_class_type fet_cls;
    logic fet_own;
    logic fet_refused;
    logic opc_cycle, data_cycle, advance, commit;
    logic ld_valid, ld_ready, dr_valid, dr_ready;
    logic [31:0] dr_data;
    logic wr_en;
    logic [3:0] wr_idx;
    logic [31:0] wr_val;
    logic ready_now;

    cpx_decoder #(
        .CP_ID(CP_ID),
        .PRIV_MASK(PRIV_MASK)
    ) u_decoder (
        .instr(fet_word_r),
        .privileged(fet_priv_r),
        .valid(fet_vld_r),
        .cls(fet_cls),
        .own(fet_own),
        .refused(fet_refused)
    );

    cpx_fifo #(
        .WIDTH(`CPX_WORD_W),
        .DEPTH(`CPX_FIFO_DEPTH)
    ) u_load_fifo (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_valid(ld_valid),
        .in_ready(ld_ready),
        .in_data(read_data),
        .out_valid(dr_valid),
        .out_ready(dr_ready),
        .out_data(dr_data)
    );

    // bus cycle classification; sequential flag adds nothing here
    assign opc_cycle = !follow_opcode_fetch_n && !follow_mem_request_n &&
                       !follow_compressed_state; // RULE6
    assign data_cycle = follow_opcode_fetch_n && !follow_mem_request_n;
    assign advance = bus_cycle_enable && opc_cycle; // RULE4 RULE22
    // commit counts once, only while our word sits in decode
    assign commit = bus_cycle_enable && dec_own_r && !dec_done_r &&
                    !coproc_commit_n && !busy_r; // RULE8 RULE12 RULE13
    // load words enter the fifo in the enabled cycle after each data cycle
    assign ld_valid = bus_cycle_enable && (xs_r == XS_LOAD) &&
                      prev_data_r && (xfer_cnt_r != '0);

    // pipeline follower
    always_comb begin
        prev_fetch_nxt = prev_fetch_r;
        prev_data_nxt = prev_data_r;
        fet_word_nxt = fet_word_r;
        fet_priv_nxt = fet_priv_r;
        fet_vld_nxt = fet_vld_r;
        dec_word_nxt = dec_word_r;
        dec_cls_nxt = dec_cls_r;
        dec_own_nxt = dec_own_r;
        dec_done_nxt = dec_done_r | commit;
        if (bus_cycle_enable) begin // RULE2
            prev_fetch_nxt = opc_cycle;
            prev_data_nxt = data_cycle;
            if (advance) begin
                // flushed words never commit, refill overwrites them
                dec_word_nxt = fet_word_r; // RULE5
                dec_cls_nxt = fet_cls;
                dec_own_nxt = fet_own;
                dec_done_nxt = 1'b0;
            end
            if (prev_fetch_r) begin
                fet_word_nxt = read_data; // RULE3 RULE16
                fet_priv_nxt = follow_privilege; // RULE20
                fet_vld_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prev_fetch_r <= 1'b0;
            prev_data_r <= 1'b0;
            fet_word_r <= 32'h0000_0000;
            fet_priv_r <= 1'b0;
            fet_vld_r <= 1'b0; // RULE1
            dec_word_r <= 32'h0000_0000;
            dec_cls_r <= CLS_NONE;
            dec_own_r <= 1'b0; // RULE1
            dec_done_r <= 1'b0;
        end else begin
            prev_fetch_r <= prev_fetch_nxt;
            prev_data_r <= prev_data_nxt;
            fet_word_r <= fet_word_nxt;
            fet_priv_r <= fet_priv_nxt;
            fet_vld_r <= fet_vld_nxt;
            dec_word_r <= dec_word_nxt;
            dec_cls_r <= dec_cls_nxt;
            dec_own_r <= dec_own_nxt;
            dec_done_r <= dec_done_nxt;
        end
    end

    // register bank write port: one source per edge
    always_comb begin
        wr_en = 1'b0;
        wr_idx = 4'h0;
        wr_val = 32'h0000_0000;
        dr_ready = 1'b0;
        if (commit && dec_cls_r == CLS_DATA_OP) begin
            wr_en = 1'b1; // RULE14
            wr_idx = dec_word_r[`CPX_F_CRD];
            wr_val = dec_word_r[`CPX_F_ALUOP] ?
                     bank_r[dec_word_r[`CPX_F_CRN]] ^
                     bank_r[dec_word_r[`CPX_F_CRM]] :
                     bank_r[dec_word_r[`CPX_F_CRN]] +
                     bank_r[dec_word_r[`CPX_F_CRM]];
        end else if (mcr_pend_r && bus_cycle_enable) begin
            wr_en = 1'b1; // RULE16
            wr_idx = mcr_reg_r;
            wr_val = write_data;
        end else if (dr_valid) begin
            // drain stalls whenever the core path owns the port
            dr_ready = 1'b1;
            wr_en = 1'b1;
            wr_idx = ptr_r;
            wr_val = dr_data;
        end
    end

    // bank written only after commit, so busy-wait stays idempotent
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            bank_r[wr_idx] <= wr_val; // RULE13
        end
    end

    // transfer sequencer and data return
    always_comb begin
        xs_nxt = xs_r;
        xfer_cnt_nxt = xfer_cnt_r;
        ptr_nxt = dr_ready ? ptr_r + 4'h1 : ptr_r;
        mcr_pend_nxt = mcr_pend_r && !bus_cycle_enable;
        mcr_reg_nxt = mcr_reg_r;
        dout_nxt = dout_r;
        drive_nxt = drive_r && !bus_cycle_enable;
        case (xs_r)
            XS_IDLE: begin
                if (commit) begin
                    case (dec_cls_r)
                        CLS_CORE_TO_CP: begin
                            mcr_pend_nxt = 1'b1;
                            mcr_reg_nxt = dec_word_r[`CPX_F_CRN];
                        end
                        CLS_CP_TO_CORE: begin
                            dout_nxt = bank_r[dec_word_r[`CPX_F_CRN]];
                            drive_nxt = 1'b1; // RULE24
                        end
                        CLS_LOAD, CLS_STORE: begin
                            xs_nxt = (dec_cls_r == CLS_LOAD) ?
                                     XS_LOAD : XS_STORE;
                            ptr_nxt = dec_word_r[`CPX_F_CRD];
                            xfer_cnt_nxt = dec_word_r[`CPX_F_LONG] ?
                                           `CPX_MAX_XFER :
                                           `CPX_ONE_XFER; // RULE15
                        end
                        default: begin
                        end
                    endcase
                end
            end
            XS_LOAD: begin
                if (ld_valid && ld_ready) begin
                    xfer_cnt_nxt = xfer_cnt_r - 5'h01;
                end
                if (xfer_cnt_r == '0) begin
                    xs_nxt = XS_IDLE;
                end
            end
            XS_STORE: begin
                if (bus_cycle_enable && data_cycle &&
                    follow_opcode_fetch_n && xfer_cnt_r != '0) begin
                    dout_nxt = bank_r[ptr_r];
                    drive_nxt = 1'b1;
                    ptr_nxt = ptr_r + 4'h1;
                    xfer_cnt_nxt = xfer_cnt_r - 5'h01;
                end
                if (xfer_cnt_r == '0 && !drive_r) begin
                    xs_nxt = XS_IDLE;
                end
            end
            default: begin
                xs_nxt = XS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            xs_r <= XS_IDLE;
            xfer_cnt_r <= 5'h00;
            ptr_r <= 4'h0;
            mcr_pend_r <= 1'b0;
            mcr_reg_r <= 4'h0;
            dout_r <= 32'h0000_0000;
            drive_r <= 1'b0;
        end else begin
            xs_r <= xs_nxt;
            xfer_cnt_r <= xfer_cnt_nxt;
            ptr_r <= ptr_nxt;
            mcr_pend_r <= mcr_pend_nxt;
            mcr_reg_r <= mcr_reg_nxt;
            dout_r <= dout_nxt;
            drive_r <= drive_nxt;
        end
    end

    // ready only with no transfer, drain or pending write in flight;
    // loads also need an empty fifo so sixteen words always fit
    assign ready_now = (xs_nxt == XS_IDLE) && !mcr_pend_nxt &&
                       !dr_valid && !drive_nxt;

    // handshake answer for the word that will sit in decode
    always_comb begin
        absent_nxt = 1'b1; // RULE9 RULE21
        busy_nxt = 1'b1;
        if (dec_own_nxt && !dec_done_nxt) begin
            absent_nxt = 1'b0;
            busy_nxt = !ready_now; // RULE10 RULE11
        end else if (dec_own_nxt) begin
            // already committed: keep the core unstalled
            absent_nxt = 1'b0;
            busy_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            absent_r <= 1'b1;
            busy_r <= 1'b1;
        end else begin
            absent_r <= absent_nxt;
            busy_r <= busy_nxt;
        end
    end

    // outputs straight from flops; system ANDs and muxes several units
    assign coproc_absent = absent_r; // RULE17
    assign coproc_busy = busy_r;
    assign coproc_data_out = dout_r;
    assign coproc_data_drive = drive_r;
endmodule : cpx_coproc
`default_nettype wire

//--- pkg/cpx_defines.svh
// constants: instruction fields, encodings and sizes for the coprocessor
`ifndef CPX_DEFINES_SVH
`define CPX_DEFINES_SVH

`define CPX_WORD_W 32
`define CPX_REG_COUNT 16
`define CPX_FIFO_DEPTH 16
`define CPX_MAX_XFER 5'h10
`define CPX_ONE_XFER 5'h01
`define CPX_ID_DEFAULT 4'h5
`define CPX_RSVD_ID_A 4'hE
`define CPX_RSVD_ID_B 4'hF
`define CPX_PRIV_MASK_DEFAULT 16'h8000

`define CPX_F_GROUP4 27:24
`define CPX_F_GROUP3 27:25
`define CPX_F_CPNUM 11:8
`define CPX_F_CRN 19:16
`define CPX_F_CRD 15:12
`define CPX_F_CRM 3:0
`define CPX_F_LOAD 20
`define CPX_F_LONG 22
`define CPX_F_XFER 4
`define CPX_F_ALUOP 20

`define CPX_GRP_REGOP 4'hE
`define CPX_GRP_LDST 3'h6

`endif

//--- pkg/cpx_pkg.sv
// types shared by the coprocessor modules
package cpx_pkg;

    // instruction class seen by the decode stage
    typedef enum logic [2:0] {
        CLS_NONE,
        CLS_DATA_OP,
        CLS_CORE_TO_CP,
        CLS_CP_TO_CORE,
        CLS_LOAD,
        CLS_STORE
    } cpx_class_type;

    // memory transfer sequencer
    typedef enum logic [1:0] {
        XS_IDLE,
        XS_LOAD,
        XS_STORE
    } cpx_xfer_type;

endpackage : cpx_pkg

//--- design/cpx_fifo.sv
// parameterised valid/ready fifo for load data
`timescale 1ns/100ps
`default_nettype none
module cpx_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r, wr_ptr_nxt;
    logic [AW-1:0] rd_ptr_r, rd_ptr_nxt;
    logic [AW:0] count_r, count_nxt;
    logic push, pop;

    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // pointer and occupancy update
    always_comb begin
        wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
        rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
        end
    end

    // storage has no reset; empty flag guards it
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end
endmodule : cpx_fifo
`default_nettype wire

//--- design/cpx_decoder.sv
// classifies a fetched word against this coprocessor's number
`timescale 1ns/100ps
`default_nettype none
`include "cpx_defines.svh"
module cpx_decoder #(
    parameter logic [3:0] CP_ID = `CPX_ID_DEFAULT,
    parameter logic [15:0] PRIV_MASK = `CPX_PRIV_MASK_DEFAULT
) (
    // word under decode
    input wire logic [31:0] instr,
    input wire logic privileged,
    input wire logic valid,
    // result
    output cpx_pkg::cpx_class_type cls,
    output logic own,
    output logic refused
);
    import cpx_pkg::*;

    // instruction class from the opcode groups
    function automatic cpx_class_type classify(input logic [31:0] w);
        cpx_class_type c;
        c = CLS_NONE;
        if (w[`CPX_F_GROUP4] == `CPX_GRP_REGOP) begin
            if (!w[`CPX_F_XFER]) begin
                c = CLS_DATA_OP;
            end else if (w[`CPX_F_LOAD]) begin
                c = CLS_CP_TO_CORE;
            end else begin
                c = CLS_CORE_TO_CP;
            end
        end else if (w[`CPX_F_GROUP3] == `CPX_GRP_LDST) begin
            c = w[`CPX_F_LOAD] ? CLS_LOAD : CLS_STORE;
        end
        return c;
    endfunction : classify

    logic match;

    // only our number counts; reserved numbers never match
    assign cls = classify(instr);
    assign match = valid && (cls != CLS_NONE) &&
                   (instr[`CPX_F_CPNUM] == CP_ID) &&
                   (CP_ID != `CPX_RSVD_ID_A) &&
                   (CP_ID != `CPX_RSVD_ID_B); // RULE7 RULE23
    // user code whose crn field names a guarded register is declined
    assign refused = match && !privileged &&
                     PRIV_MASK[instr[`CPX_F_CRN]]; // RULE20 RULE21
    assign own = match && !refused;
endmodule : cpx_decoder
`default_nettype wire

//--- bench/cpx_coproc_props.sv
// port checker for the coprocessor
`timescale 1ns/100ps
`default_nettype none
module cpx_coproc_props (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic bus_cycle_enable,
    // pipeline following
    input wire logic follow_mem_request_n,
    input wire logic follow_sequential,
    input wire logic follow_privilege,
    input wire logic follow_opcode_fetch_n,
    input wire logic follow_compressed_state,
    // handshake
    input wire logic coproc_commit_n,
    input wire logic coproc_absent,
    input wire logic coproc_busy,
    // data
    input wire logic [31:0] read_data,
    input wire logic [31:0] write_data,
    input wire logic [31:0] coproc_data_out,
    input wire logic coproc_data_drive
);
    logic adv;
    logic dcyc;
    // advance: enabled edge of a full-width opcode fetch
    assign adv = bus_cycle_enable && !follow_opcode_fetch_n
        && !follow_mem_request_n && !follow_compressed_state;
    // data cycle: memory request that is no opcode fetch
    assign dcyc = follow_opcode_fetch_n && !follow_mem_request_n;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    a_reset_declines: assert property (
        $fell(sys_rst) |-> coproc_absent && coproc_busy && !coproc_data_drive)
        else $error("outputs not at rest after reset");
    a_stall_holds: assert property (
        !bus_cycle_enable |=> $stable(coproc_data_out)
        && $stable(coproc_data_drive)) else $error("data moved in a stall");
    a_decline_pair: assert property (
        coproc_absent |-> coproc_busy) else $error("absent without busy");
    a_refused_quiet: assert property (
        coproc_absent |-> !coproc_data_drive) else $error("drive while absent");
    a_drive_cause: assert property (
        $rose(coproc_data_drive) |-> $past(bus_cycle_enable)
        && $past(!coproc_commit_n || dcyc)) else $error("drive without cause");
    a_drive_ends: assert property (
        coproc_data_drive && bus_cycle_enable && coproc_commit_n && !dcyc
        |=> !coproc_data_drive) else $error("drive outlived its cycle");
    a_wait_bounded: assert property (
        !coproc_absent && coproc_busy |-> ##[0:300] !coproc_busy)
        else $error("busy-wait never ended");
    a_decline_holds: assert property (
        coproc_absent && !adv && !$past(adv) |=> coproc_absent)
        else $error("answer changed without advance");
    a_accept_holds: assert property (
        !coproc_absent && !adv && !$past(adv) |=> !coproc_absent)
        else $error("accept dropped without advance");
endmodule : cpx_coproc_props
bind cpx_coproc cpx_coproc_props u_props (.*);
`default_nettype wire

//--- bench/cpx_core_model.sv
// behavioural core: bus cycles, stalls, fetch stream and commit
`timescale 1ns/100ps
`default_nettype none
module cpx_core_model (
    // clock
    input wire logic sys_clk,
    // pacing and pipeline following
    output logic bus_cycle_enable,
    output logic follow_mem_request_n,
    output logic follow_sequential,
    output logic follow_privilege,
    output logic follow_opcode_fetch_n,
    output logic follow_compressed_state,
    // handshake
    output logic coproc_commit_n,
    input wire logic coproc_absent,
    input wire logic coproc_busy,
    // data
    output logic [31:0] read_data,
    output logic [31:0] write_data
);
    localparam logic [4:0] IDLE = 5'h1B;
    localparam logic [4:0] DATA = 5'h13;
    // quiet bus until the first cycle
    initial begin
        {follow_opcode_fetch_n, follow_mem_request_n, follow_compressed_state,
            follow_privilege, coproc_commit_n} = IDLE;
        bus_cycle_enable = 1'h1;
        follow_sequential = 1'h0;
        read_data = 32'h0;
        write_data = 32'h0;
    end
    // one bus cycle; stalled clocks carry junk, never a stale value
    task automatic cyc(input logic [4:0] ctl, input logic [31:0] rd, wd);
        int n;
        n = $urandom_range(0, 2);
        {follow_opcode_fetch_n, follow_mem_request_n, follow_compressed_state,
            follow_privilege, coproc_commit_n} = ctl;
        follow_sequential = $urandom_range(0, 1);
        repeat (n) begin
            bus_cycle_enable = 1'h0;
            read_data = $urandom();
            write_data = $urandom();
            @(posedge sys_clk);
            #1;
        end
        bus_cycle_enable = 1'h1;
        read_data = rd;
        write_data = wd;
        @(posedge sys_clk);
        #1;
    endtask : cyc
    // fetch a word, wait out busy-wait, commit only an accepted one
    task automatic run(input logic [31:0] w, input logic go, priv, comp,
            input logic [31:0] wd, input int nd, input logic [31:0] ld [16],
            output logic [1:0] resp);
        logic [4:0] f;
        f = {2'h0, comp, priv, 1'h1};
        cyc(f, 32'h0, 32'h0);
        cyc(f, w, 32'h0);
        cyc(f, 32'h0, 32'h0);
        cyc(IDLE, 32'h0, 32'h0);
        for (int i = 0; i < 60 && coproc_absent === 1'h0
                && coproc_busy === 1'h1; i++) begin
            cyc(IDLE, 32'h0, 32'h0);
        end
        resp = {coproc_absent, coproc_busy};
        if (go && resp === 2'h0) begin
            cyc(5'h1A, 32'h0, 32'h0);
            cyc(IDLE, 32'h0, wd);
            for (int i = 0; i < nd; i++) begin
                cyc(DATA, i ? ld[i-1] : 32'h0, 32'h0);
            end
            cyc(IDLE, nd ? ld[nd-1] : 32'h0, 32'h0);
        end
    endtask : run
endmodule : cpx_core_model
`default_nettype wire

//--- bench/test_coproc_pipeline_handshake.sv
// self-checking bench for the coprocessor pipeline follower
`timescale 1ns/100ps
`default_nettype none
`include "cpx_defines.svh"
module test_coproc_pipeline_handshake;
    logic sys_clk, sys_rst, bus_cycle_enable, follow_mem_request_n;
    logic follow_sequential, follow_privilege, follow_opcode_fetch_n;
    logic follow_compressed_state, coproc_commit_n, coproc_absent;
    logic coproc_busy, coproc_data_drive;
    logic [31:0] read_data, write_data, coproc_data_out;
    logic [31:0] bank [16];
    logic [31:0] ld [16];
    logic [31:0] exp_q [$];
    logic [1:0] resp;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    localparam logic [3:0] ID = `CPX_ID_DEFAULT;
    // clock source
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    cpx_coproc uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .bus_cycle_enable(bus_cycle_enable),
        .follow_mem_request_n(follow_mem_request_n),
        .follow_sequential(follow_sequential),
        .follow_privilege(follow_privilege),
        .follow_opcode_fetch_n(follow_opcode_fetch_n),
        .follow_compressed_state(follow_compressed_state),
        .coproc_commit_n(coproc_commit_n), .coproc_absent(coproc_absent),
        .coproc_busy(coproc_busy), .read_data(read_data),
        .write_data(write_data), .coproc_data_out(coproc_data_out),
        .coproc_data_drive(coproc_data_drive));
    cpx_core_model u_core (.sys_clk(sys_clk),
        .bus_cycle_enable(bus_cycle_enable),
        .follow_mem_request_n(follow_mem_request_n),
        .follow_sequential(follow_sequential),
        .follow_privilege(follow_privilege),
        .follow_opcode_fetch_n(follow_opcode_fetch_n),
        .follow_compressed_state(follow_compressed_state),
        .coproc_commit_n(coproc_commit_n), .coproc_absent(coproc_absent),
        .coproc_busy(coproc_busy), .read_data(read_data),
        .write_data(write_data));
    // register-class word: l = to core, x = move rather than data op
    function automatic logic [31:0] rop(logic [3:0] cp, logic l, x,
            logic [3:0] crn, crd, crm);
        return {8'hEE, 3'h0, l, crn, crd, cp, 3'h0, x, crm};
    endfunction : rop
    // memory-class word, one or sixteen words from crd upward
    function automatic logic [31:0] lsop(logic load, long, logic [3:0] crd);
        return {4'hE, 3'h6, 2'h3, long, 1'h0, load, 4'h0, crd, ID, 8'h00};
    endfunction : lsop
    task automatic check_data(input string what, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : check_data
    task automatic check_resp(input string what, input logic [1:0] e, g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : check_resp
    // one instruction through the core, answer compared
    task automatic step(input logic [31:0] w, input logic [1:0] e,
            input logic go = 1'h1, priv = 1'h1, comp = 1'h0,
            input logic [31:0] wd = 32'h0, input int nd = 0);
        u_core.run(w, go, priv, comp, wd, nd, ld, resp);
        check_resp("handshake", e, resp);
    endtask : step
    task automatic put(input logic [3:0] r, input logic [31:0] v);
        bank[r] = v;
        step(rop(ID, 1'h0, 1'h1, r, 4'h0, 4'h0), 2'h0, 1'h1, 1'h1, 1'h0, v);
    endtask : put
    task automatic get(input logic [3:0] r);
        exp_q.push_back(bank[r]);
        step(rop(ID, 1'h1, 1'h1, r, 4'h0, 4'h0), 2'h0);
    endtask : get
    task automatic end_of_test;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // watcher: each driven word takes the oldest note
    always @(posedge sys_clk) begin
        if (sys_rst === 1'h0 && bus_cycle_enable === 1'h1
                && coproc_data_drive === 1'h1) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("ERROR data_out expected none seen %h",
                    coproc_data_out);
            end else begin
                check_data("data_out", exp_q.pop_front(), coproc_data_out);
            end
        end
    end
    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        sys_rst = 1'h1;
        void'($urandom(32'hB003));
        repeat (16) @(posedge sys_clk);
        #1;
        sys_rst = 1'h0;
        check_resp("reset", 2'h3, {coproc_absent, coproc_busy});
        $display("test reset done");
        for (int i = 1; i < 4; i++) put(i[3:0], $urandom());
        put(4'hF, $urandom());
        step(rop(ID, 1'h0, 1'h0, 4'h1, 4'h4, 4'h2), 2'h0);
        bank[4] = bank[1] + bank[2];
        step(rop(ID, 1'h1, 1'h0, 4'h1, 4'h5, 4'h3), 2'h0);
        bank[5] = bank[1] ^ bank[3];
        for (int i = 1; i < 6; i++) get(i[3:0]);
        exp_q.push_back(bank[2]);
        step(rop(ID, 1'h1, 1'h1, 4'h2, 4'h0, 4'h0), 2'h0, 1'h1, 1'h0);
        $display("test moves done");
        step(rop(4'h6, 1'h1, 1'h1, 4'h1, 4'h0, 4'h0), 2'h3);
        step(rop(`CPX_RSVD_ID_A, 1'h1, 1'h1, 4'h1, 4'h0, 4'h0), 2'h3);
        step(rop(ID, 1'h0, 1'h1, 4'hF, 4'h0, 4'h0), 2'h3, 1'h1, 1'h0);
        step(32'hE1A01002, 2'h3);
        get(4'hF);
        $display("test declines done");
        step(rop(ID, 1'h0, 1'h0, 4'h2, 4'h1, 4'h3), 2'h0, 1'h0);
        get(4'h1);
        step(rop(ID, 1'h1, 1'h1, 4'h1, 4'h0, 4'h0), 2'h0, 1'h1, 1'h1, 1'h1);
        step(32'h0, 2'h3);
        $display("test abandon done");
        for (int i = 0; i < 16; i++) ld[i] = $urandom();
        step(lsop(1'h1, 1'h1, 4'h0), 2'h0, 1'h1, 1'h1, 1'h0, 32'h0, 16);
        for (int i = 0; i < 16; i++) bank[i] = ld[i];
        for (int i = 0; i < 16; i++) get(i[3:0]);
        ld[0] = $urandom();
        bank[7] = ld[0];
        step(lsop(1'h1, 1'h0, 4'h7), 2'h0, 1'h1, 1'h1, 1'h0, 32'h0, 1);
        exp_q.push_back(bank[7]);
        step(lsop(1'h0, 1'h0, 4'h7), 2'h0, 1'h1, 1'h1, 1'h0, 32'h0, 1);
        repeat (4) @(posedge sys_clk);
        check_data("pending", 32'h0, 32'(exp_q.size()));
        $display("test memory done");
        end_of_test();
    end
endmodule : test_coproc_pipeline_handshake
`default_nettype wire
